// File: core/wdt_core.sv
// Watchdog timer control with an AHB-Lite register slave.
// Assumes one master, single word transfers, mclk is the fast clock.
//
// How it works
// - Writing 1 to the run-enable field starts the watchdog counter.
// - Writing 0 to run-enable alone does not stop it; a disable code is needed.
// - The period field picks 2^25..2^19 fast cycles or 2^17..2^11 slow ones.
// - The action field picks interrupt (0) or reset (1) on overflow.
// - Once action is 0, writes of 1 are ignored until reset.
// - The control register is write-only; it reads as zero here.
// - The disable code acts only while run-enable holds 0.
// - Run-enable resets to 1 so the watchdog runs after reset.
// - Overflow with action 1 drives the reset pin low for 24 fast cycles.
// - Overflow with action 0 raises the non-maskable watchdog interrupt.
//
// The AHB-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module wdt_core #(
  parameter int FAST_EXP = wdt_pkg::FAST_EXP_TOP,
  parameter int SLOW_EXP = wdt_pkg::SLOW_EXP_TOP,
  parameter int SLOW_DIV = wdt_pkg::SLOW_DIV
) (
  input wire logic mclk,           // System and fast clock
  input wire logic rst,            // Async reset, high
  input wire logic hsel,           // AHB select
  input wire logic [7:0] haddr,    // AHB byte address
  input wire logic [1:0] htrans,   // AHB transfer type
  input wire logic hwrite,         // AHB write
  input wire logic [2:0] hsize,    // AHB size
  input wire logic [31:0] hwdata,  // AHB write data
  input wire logic hready,         // AHB bus ready
  input wire logic stopMode,       // Oscillator stopped
  output logic [31:0] hrdata,      // AHB read data
  output logic hreadyout,          // AHB slave ready
  output logic hresp,              // AHB response, always OKAY
  output logic wdogNmiRequest,     // One-cycle NMI request
  output logic wdogResetReq,       // Reset request level
  output logic resetOutN,          // Reset pin drive, low active
  output logic irq                 // Interrupt level
);
  localparam int CW = FAST_EXP + 1;

  // ==========================================================
  // Slow-clock enable
  logic slowTick;
  wdt_tick_div #(.DIV(SLOW_DIV)) u_div (
    .mclk(mclk),
    .rst(rst),
    .tick(slowTick)
  );

  // ==========================================================
  // Bus slave
  logic wrPend_r, wrPend_nxt;
  logic [7:0] wrAddr_r, wrAddr_nxt;
  logic [31:0] hrdata_nxt;
  logic addrTaken, rdStatus;

  // ==========================================================
  // Control state
  logic runEn_r, runEn_nxt;
  logic active_r, active_nxt;
  logic actSel_r, actSel_nxt;
  logic [1:0] period_r, period_nxt;
  logic [1:0] config_r, config_nxt;
  logic [1:0] status_r, status_nxt;
  logic [1:0] mask_r, mask_nxt;
  logic [CW-1:0] count_r, count_nxt;
  logic nmi_nxt, irq_nxt;
  logic wrCtrl, wrCode, slowSrc, cntTick, overflow;
  logic [CW-1:0] limit;
  logic [7:0] wdata8;
  logic [CW+23:0] cntWide;

  // ==========================================================
  // Reset pulse
  wdt_pkg::wdt_pulse_t pulse_r, pulse_nxt;
  logic [4:0] pulseCnt_r, pulseCnt_nxt;
  logic resetOutN_nxt, resetReq_nxt;

  always_comb begin
    addrTaken = hsel && hready && htrans[1];
    rdStatus = addrTaken && !hwrite && haddr == wdt_pkg::OFS_STATUS;
    wrPend_nxt = addrTaken && hwrite;
    wrAddr_nxt = addrTaken ? haddr : wrAddr_r;
    hrdata_nxt = hrdata;
    // Zero padded below so short counters still fill the field
    cntWide = {count_r, 24'h000000};
    if (addrTaken && !hwrite) begin
      hrdata_nxt = 32'h0000_0000;
      unique case (haddr)
        wdt_pkg::OFS_CONFIG: hrdata_nxt[1:0] = config_r;
        wdt_pkg::OFS_STATUS: hrdata_nxt[1:0] = status_r;
        wdt_pkg::OFS_MASK: hrdata_nxt[1:0] = mask_r;
        wdt_pkg::OFS_STATE: begin
          hrdata_nxt[wdt_pkg::STATE_ACTIVE_BIT] = active_r;
          hrdata_nxt[wdt_pkg::STATE_EN_BIT] = runEn_r;
          hrdata_nxt[wdt_pkg::STATE_ACT_BIT] = actSel_r;
          hrdata_nxt[wdt_pkg::STATE_PER_LO +: 2] = period_r;
          hrdata_nxt[wdt_pkg::STATE_CNT_LO +: 24] = cntWide[CW+23 -: 24];
        end
        default: hrdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      wrPend_r <= wrPend_nxt;
      wrAddr_r <= wrAddr_nxt;
      hrdata <= hrdata_nxt;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Watchdog counter and control
  always_comb begin
    wdata8 = hwdata[7:0];
    wrCtrl = wrPend_r && wrAddr_r == wdt_pkg::OFS_CTRL_A;
    wrCode = wrPend_r && wrAddr_r == wdt_pkg::OFS_CODE;
    slowSrc = config_r[wdt_pkg::CFG_SRC_BIT] ||
              config_r[wdt_pkg::CFG_SLOW_BIT];
    cntTick = active_r && !stopMode && (slowSrc ? slowTick : 1'b1);
    limit = '0;
    limit[slowSrc ? SLOW_EXP - 2 * period_r
                  : FAST_EXP - 2 * period_r] = 1'b1;
    overflow = cntTick && (count_r == limit - CW'(1));
    runEn_nxt = runEn_r;
    active_nxt = active_r;
    actSel_nxt = actSel_r;
    period_nxt = period_r;
    config_nxt = config_r;
    mask_nxt = mask_r;
    count_nxt = cntTick ? count_r + CW'(1) : count_r;
    if (overflow) begin
      count_nxt = '0;
    end
    if (wrCtrl) begin
      runEn_nxt = wdata8[wdt_pkg::CTRL_EN_BIT];
      if (wdata8[wdt_pkg::CTRL_EN_BIT]) begin
        active_nxt = 1'b1;
      end  // A written 0 leaves the counter running
      period_nxt = wdata8[wdt_pkg::CTRL_PER_LO +: 2];
      actSel_nxt = actSel_r & wdata8[wdt_pkg::CTRL_ACT_BIT];
    end
    if (wrCode) begin
      if (wdata8 == wdt_pkg::CODE_CLEAR) begin
        count_nxt = '0;
      end else if (wdata8 == wdt_pkg::CODE_DISABLE && !runEn_r) begin
        active_nxt = 1'b0;
      end  // Any other code is ignored
    end
    if (!active_nxt) begin
      count_nxt = '0;  // Disabled watchdog holds a cleared counter
    end
    if (wrPend_r && wrAddr_r == wdt_pkg::OFS_CONFIG) begin
      config_nxt = hwdata[1:0];
    end
    if (wrPend_r && wrAddr_r == wdt_pkg::OFS_MASK) begin
      mask_nxt = hwdata[1:0];
    end
    nmi_nxt = overflow && !actSel_r;
    // Set beats a same-cycle read clear
    status_nxt = rdStatus ? 2'b00 : status_r;
    status_nxt[wdt_pkg::ST_NMI_BIT] = status_nxt[wdt_pkg::ST_NMI_BIT] |
                                      nmi_nxt;
    status_nxt[wdt_pkg::ST_RST_BIT] = status_nxt[wdt_pkg::ST_RST_BIT] |
                                      (overflow && actSel_r);
    irq_nxt = |(status_nxt & mask_nxt);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      runEn_r <= wdt_pkg::RST_RUN_EN;
      active_r <= wdt_pkg::RST_RUN_EN;
      actSel_r <= wdt_pkg::RST_ACT_SEL;
      period_r <= wdt_pkg::RST_PERIOD;
      config_r <= wdt_pkg::RST_CONFIG;
      mask_r <= wdt_pkg::RST_MASK;
      status_r <= 2'b00;
      count_r <= '0;
      wdogNmiRequest <= 1'b0;
      irq <= 1'b0;
    end else begin
      runEn_r <= runEn_nxt;
      active_r <= active_nxt;
      actSel_r <= actSel_nxt;
      period_r <= period_nxt;
      config_r <= config_nxt;
      mask_r <= mask_nxt;
      status_r <= status_nxt;
      count_r <= count_nxt;
      wdogNmiRequest <= nmi_nxt;
      irq <= irq_nxt;
    end
  end

  // ==========================================================
  // Reset pulse generator
  always_comb begin
    pulse_nxt = pulse_r;
    pulseCnt_nxt = pulseCnt_r;
    unique case (pulse_r)
      wdt_pkg::PULSE_IDLE: begin
        if (overflow && actSel_r) begin
          pulse_nxt = wdt_pkg::PULSE_LOW;
          pulseCnt_nxt = 5'(wdt_pkg::RESET_PULSE_CYC - 1);
        end
      end
      wdt_pkg::PULSE_LOW: begin
        if (pulseCnt_r == 5'h00) begin
          pulse_nxt = wdt_pkg::PULSE_IDLE;
        end else begin
          pulseCnt_nxt = pulseCnt_r - 5'h01;
        end
      end
      default: begin
        pulse_nxt = wdt_pkg::PULSE_IDLE;
        pulseCnt_nxt = 5'h00;
      end
    endcase
    resetReq_nxt = pulse_nxt == wdt_pkg::PULSE_LOW;
    resetOutN_nxt = !resetReq_nxt;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pulse_r <= wdt_pkg::PULSE_IDLE;
      pulseCnt_r <= 5'h00;
      wdogResetReq <= 1'b0;
      resetOutN <= 1'b1;
    end else begin
      pulse_r <= pulse_nxt;
      pulseCnt_r <= pulseCnt_nxt;
      wdogResetReq <= resetReq_nxt;
      resetOutN <= resetOutN_nxt;
    end
  end
endmodule // wdt_core

// File: core/wdt_pkg.sv
// Watchdog package: register map, field layout, reset values, timing counts.
// Assumes a single 200 MHz clock that also serves as the fast clock.
package wdt_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL_A = 8'h00;
  localparam logic [7:0] OFS_CODE = 8'h04;
  localparam logic [7:0] OFS_CONFIG = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_STATE = 8'h14;

  // ==========================================================
  // Field positions
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_PER_LO = 2;
  localparam int CTRL_ACT_BIT = 1;
  localparam int CFG_SRC_BIT = 0;
  localparam int CFG_SLOW_BIT = 1;
  localparam int ST_NMI_BIT = 0;
  localparam int ST_RST_BIT = 1;
  localparam int STATE_ACTIVE_BIT = 0;
  localparam int STATE_EN_BIT = 1;
  localparam int STATE_ACT_BIT = 2;
  localparam int STATE_PER_LO = 4;
  localparam int STATE_CNT_LO = 8;

  // ==========================================================
  // Codes and reset values
  localparam logic [7:0] CODE_CLEAR = 8'h4E;
  localparam logic [7:0] CODE_DISABLE = 8'hB1;
  localparam logic RST_RUN_EN = 1'b1;
  localparam logic RST_ACT_SEL = 1'b1;
  localparam logic [1:0] RST_PERIOD = 2'h0;
  localparam logic [1:0] RST_CONFIG = 2'h0;
  localparam logic [1:0] RST_MASK = 2'h3;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int RESET_PULSE_FC = 24;   // fast-clock periods, at most
  localparam int RESET_PULSE_CYC = RESET_PULSE_FC;  // fast clock is mclk
  localparam int FAST_EXP_TOP = 25;
  localparam int SLOW_EXP_TOP = 17;
  localparam int SLOW_CLK_HZ = 32768;
  localparam int MCLK_HZ = 1000000000 / (CLK_PERIOD_PS / 1000);
  localparam int SLOW_DIV = MCLK_HZ / SLOW_CLK_HZ;

  typedef enum logic [1:0] {
    PULSE_IDLE = 2'b01,
    PULSE_LOW = 2'b10
  } wdt_pulse_t;

endpackage

// File: core/wdt_tick_div.sv
// Divider that turns mclk into a one-cycle enable at a slower rate.
// Assumes DIV >= 1; the tick is a single mclk cycle wide.
`timescale 1ns/1ps
module wdt_tick_div #(
  parameter int DIV = 6103
) (
  input wire logic mclk,   // System clock
  input wire logic rst,    // Async reset, high
  output logic tick        // One-cycle enable
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic tick_nxt;

  always_comb begin
    tick_nxt = (cnt_r == LAST);
    cnt_nxt = tick_nxt ? '0 : cnt_r + W'(1);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_r <= '0;
      tick <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick <= tick_nxt;
    end
  end
endmodule // wdt_tick_div

// File: test/wdt_core_asserts.sv
// Checker for the watchdog core: bus answers and request pulse shapes.
// Assumes it is bound to wdt_core; one clock, async active-high reset.
`timescale 1ns/1ps
module wdt_core_asserts (
  input wire logic mclk, // Clock
  input wire logic rst, // Reset
  input wire logic hsel, // Select
  input wire logic [7:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic hready, // Bus ready
  input wire logic [31:0] hrdata, // Read data
  input wire logic hreadyout, // Slave ready
  input wire logic hresp, // Response
  input wire logic wdogNmiRequest, // NMI pulse
  input wire logic wdogResetReq, // Reset request
  input wire logic resetOutN // Reset pin
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ==========================================
  // Reset pin low-time counter
  logic [5:0] lowCnt_r;
  logic [5:0] lowCnt_nxt;
  logic rdTaken;
  assign rdTaken = hsel && hready && htrans[1] && !hwrite;
  always_comb lowCnt_nxt = resetOutN ? 6'h00 : lowCnt_r + 6'h01;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) lowCnt_r <= 6'h00;
    else lowCnt_r <= lowCnt_nxt;
  end
  // ==========================================
  // Properties
  pulse_len_a: assert property ($rose(resetOutN) |->
    lowCnt_r == 6'h18) else $error("reset pin low time is not 24 cycles");
  pulse_cap_a: assert property (lowCnt_r <= 6'h18)
    else $error("reset pin held low too long");
  pin_match_a: assert property (wdogResetReq == !resetOutN)
    else $error("reset request and pin disagree");
  nmi_single_a: assert property (wdogNmiRequest |=> !wdogNmiRequest)
    else $error("NMI pulse longer than one cycle");
  bus_okay_a: assert property (!hresp)
    else $error("response not OKAY");
  zero_wait_a: assert property (!$past(rst) |-> hreadyout)
    else $error("slave inserted a wait state");
  ctrl_read_a: assert property (rdTaken &&
    haddr == wdt_pkg::OFS_CTRL_A |=> hrdata == 32'h0)
    else $error("control register read not zero");
  gap_read_a: assert property (rdTaken && haddr > wdt_pkg::OFS_STATE
    |=> hrdata == 32'h0) else $error("unmapped read not zero");
  cover property ($fell(resetOutN));
  cover property (wdogNmiRequest);
  cover property (rdTaken && haddr == wdt_pkg::OFS_CTRL_A);
endmodule // wdt_core_asserts

bind wdt_core wdt_core_asserts u_wdt_core_asserts (.mclk, .rst, .hsel,
  .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
  .wdogNmiRequest, .wdogResetReq, .resetOutN);

// File: test/testbench.sv
// Self-checking bench for the watchdog core over AHB-Lite.
// Assumes short sim counts: 2^8 fast cycles, slow tick every 4 cycles.
`timescale 1ns/1ps
module testbench;
  logic mclk, rst, hsel, hwrite, hready, stopMode;
  logic [7:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, rdat;
  logic hreadyout, hresp, wdogNmiRequest, wdogResetReq, resetOutN, irq;
  int bad_count = 0;
  int comparisons = 0;
  int n;
  typedef struct packed {
    logic w; logic [7:0] a; logic [31:0] d; logic [31:0] m; logic [31:0] e;
  } wdt_row_t;
  wdt_row_t rows [13] = '{
    '{1'b0, wdt_pkg::OFS_STATE, 32'h0, 32'h37, 32'h07},
    '{1'b0, wdt_pkg::OFS_MASK, 32'h0, 32'hFF, 32'h03},
    '{1'b0, wdt_pkg::OFS_CONFIG, 32'h0, 32'hFF, 32'h00},
    '{1'b0, wdt_pkg::OFS_STATUS, 32'h0, 32'hFF, 32'h00},
    '{1'b0, wdt_pkg::OFS_CTRL_A, 32'h0, 32'hFFFFFFFF, 32'h0},
    '{1'b0, 8'h18, 32'h0, 32'hFFFFFFFF, 32'h0},
    '{1'b1, 8'h18, 32'hFF, 32'h0, 32'h0},
    '{1'b1, wdt_pkg::OFS_MASK, 32'h1, 32'h0, 32'h0},
    '{1'b0, wdt_pkg::OFS_MASK, 32'h0, 32'hFF, 32'h01},
    '{1'b1, wdt_pkg::OFS_CONFIG, 32'h3, 32'h0, 32'h0},
    '{1'b0, wdt_pkg::OFS_CONFIG, 32'h0, 32'hFF, 32'h03},
    '{1'b1, wdt_pkg::OFS_CONFIG, 32'h0, 32'h0, 32'h0},
    '{1'b1, wdt_pkg::OFS_MASK, 32'h3, 32'h0, 32'h0}};
  int per [6][3] = '{'{0, 0, 256}, '{0, 1, 64}, '{0, 2, 16}, '{0, 3, 4},
    '{1, 3, 8}, '{2, 2, 32}};
  assign hready = hreadyout;

  wdt_core #(.FAST_EXP(8), .SLOW_EXP(7), .SLOW_DIV(4)) u_wdt_core (
    .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .stopMode(stopMode), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .wdogNmiRequest(wdogNmiRequest),
    .wdogResetReq(wdogResetReq), .resetOutN(resetOutN), .irq(irq));

  // ==========================================
  // Bus and compare tasks
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    // Requests start right after a rising edge
    if (mclk !== 1'b1) @(posedge mclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    rdat = hrdata;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stChk(input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, wdt_pkg::OFS_STATE, 32'h0);
    check(rdat & m, e);
  endtask

  // Counts falling edges until the chosen output event, 3000 at most;
  // returns on the next rising edge so drivers stay edge aligned
  task automatic waitFor(input int sel, output int k);
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while (k < 3000 && !(sel == 0 ? wdogNmiRequest === 1'b1 :
      sel == 1 ? resetOutN === 1'b0 : resetOutN === 1'b1));
    @(posedge mclk);
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    end_sim();
  end

  // ==========================================
  // Main sequence
  initial begin
    {rst, hsel, hwrite, stopMode, haddr, htrans, hwdata} = '0;
    rst = 1'b1;
    hsize = 3'h2;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    foreach (rows[i]) begin
      xfer(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) check(rdat & rows[i].m, rows[i].e);
    end
    xfer(1'b1, wdt_pkg::OFS_CODE, 32'h4E);
    waitFor(1, n);
    check(32'(n >= 250 && n <= 262), 32'h1);
    waitFor(2, n);
    check(32'(n), 32'h18);
    xfer(1'b1, wdt_pkg::OFS_MASK, 32'h1);
    @(negedge mclk);
    check(32'(irq), 32'h0);
    xfer(1'b1, wdt_pkg::OFS_MASK, 32'h3);
    @(negedge mclk);
    check(32'(irq), 32'h1);
    xfer(1'b0, wdt_pkg::OFS_STATUS, 32'h0);
    check(rdat, 32'h2);
    xfer(1'b0, wdt_pkg::OFS_STATUS, 32'h0);
    check(rdat, 32'h0);
    @(negedge mclk);
    check(32'(irq), 32'h0);
    // Period codes, fast and slow, measured between NMI pulses
    foreach (per[i]) begin
      xfer(1'b1, wdt_pkg::OFS_CONFIG, 32'(per[i][0]));
      xfer(1'b1, wdt_pkg::OFS_CTRL_A, 32'h80 | 32'(per[i][1] << 2));
      waitFor(0, n);
      waitFor(0, n);
      check(32'(n), 32'(per[i][2]));
    end
    xfer(1'b1, wdt_pkg::OFS_CONFIG, 32'h0);
    xfer(1'b1, wdt_pkg::OFS_CTRL_A, 32'h82);
    stChk(32'h4, 32'h0);
    xfer(1'b1, wdt_pkg::OFS_CODE, 32'h4E);
    xfer(1'b1, wdt_pkg::OFS_CODE, 32'hB1);
    stChk(32'h1, 32'h1);
    xfer(1'b1, wdt_pkg::OFS_CTRL_A, 32'h0);
    stChk(32'h1, 32'h1);
    xfer(1'b1, wdt_pkg::OFS_CODE, 32'h55);
    stChk(32'h1, 32'h1);
    xfer(1'b1, wdt_pkg::OFS_CODE, 32'hB1);
    stChk(32'h3, 32'h0);
    waitFor(0, n);
    check(32'(n), 32'(3000));
    xfer(1'b1, wdt_pkg::OFS_CTRL_A, 32'h80);
    stChk(32'h3, 32'h3);
    // Clears inside 3/4 of the period keep events away
    xfer(1'b0, wdt_pkg::OFS_STATUS, 32'h0);
    repeat (4) begin
      repeat (150) @(posedge mclk);
      xfer(1'b1, wdt_pkg::OFS_CODE, 32'h4E);
    end
    xfer(1'b0, wdt_pkg::OFS_STATUS, 32'h0);
    check(rdat, 32'h0);
    // STOP freezes the counter; clear before entry and after release
    xfer(1'b1, wdt_pkg::OFS_CODE, 32'h4E);
    stopMode <= 1'b1;
    waitFor(0, n);
    check(32'(n), 32'(3000));
    stopMode <= 1'b0;
    xfer(1'b1, wdt_pkg::OFS_CODE, 32'h4E);
    waitFor(0, n);
    check(32'(n), 32'(257));
    // Mid-run reset restores the reset action and run-enable
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    check(32'({resetOutN, irq, wdogNmiRequest}), 32'h4);
    @(posedge mclk);
    stChk(32'h37, 32'h07);
    end_sim();
  end
endmodule // testbench
